// File: dv/sadc_conv_model.sv
// Behavioural model of the external serial converter.
`timescale 1ns/100ps
`default_nettype none
module sadc_conv_model (
   // Clock
   input wire logic sys_clk_i,
   // Link from the port
   input wire sadc_pkg::sadc_link_s link_i,
   // Frame set-up from the bench
   input wire logic [4:0] len_i,
   input wire logic [15:0] pat_i,
   // Serial data to the port
   output logic sdo_o
);
   import sadc_pkg::*;
   logic sc_q = 1'b0;
   logic sp_q = 1'b0;
   logic act_q = 1'b0;
   logic [4:0] idx_q = 5'h00;
   logic sd_q = 1'b0;
   assign sdo_o = sd_q;
   // A frame starts at the sync pulse; each bit is replaced at the falling
   // shift clock edge. Outside a frame the line toggles every cycle, so a
   // stale bit can never pass for data.
   always @(posedge sys_clk_i) begin
      sc_q <= link_i.shift_clk;
      sp_q <= link_i.sync_pulse;
      if (link_i.sync_pulse && !sp_q) begin
         act_q <= 1'b1;
         idx_q <= 5'h00;
         sd_q <= pat_i[15];
      end else if (act_q && sc_q && !link_i.shift_clk) begin
         idx_q <= idx_q + 5'h01;
         if (idx_q + 5'h01 >= len_i) begin
            act_q <= 1'b0;
         end else begin
            sd_q <= pat_i[4'he - idx_q[3:0]];
         end
      end else if (!act_q) begin
         sd_q <= ~sd_q;
      end
   end
endmodule
`default_nettype wire

// File: dv/test_sadc_top.sv
// Self-checking bench for the serial converter port.
`timescale 1ns/100ps
`default_nettype none
module test_sadc_top;
   import sadc_pkg::*;
   logic sys_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic sdi, irq, sc_d, sp_d, sk_d, sync_ok;
   logic [7:0] shb;
   logic [4:0] m_len = 5'h00;
   logic [15:0] m_pat = 16'h0000;
   sadc_axi_req_s axi_q = '0;
   sadc_axi_rsp_s axi_rsp;
   sadc_link_s link;
   int miscompares = 0;
   int compares = 0;
   int fr_n = 0;
   int sk_n = 0;

   sadc_top dut_u (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .axi_i(axi_q),
      .axi_o(axi_rsp), .converter_serial_in_i(sdi), .link_o(link),
      .irq_o(irq));
   sadc_conv_model conv_u (.sys_clk_i(sys_clk_i), .link_i(link),
      .len_i(m_len), .pat_i(m_pat), .sdo_o(sdi));

   initial begin
      forever #50 sys_clk_i = ~sys_clk_i;
   end

   // --------------------------------------------------------------------
   // Link monitor, sampled at the falling edge where all is settled
   // --------------------------------------------------------------------
   always @(negedge sys_clk_i) begin
      sc_d <= link.shift_clk;
      sp_d <= link.sync_pulse;
      sk_d <= link.sample_clk;
      if (link.sync_pulse) begin
         fr_n <= 0;
      end else if (link.shift_clk && !sc_d) begin
         if (fr_n == 0) sync_ok <= sp_d;
         if (fr_n < 8) shb <= {shb[6:0], link.serial_out};
         fr_n <= fr_n + 1;
      end
      if (link.sample_clk && !sk_d) sk_n <= sk_n + 1;
   end

   // --------------------------------------------------------------------
   // Compare and bus tasks
   // --------------------------------------------------------------------
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t resp %h exp %h", $time, got, exp);
      end
   endtask

   // Ready and valid are taken at the falling edge before the rising edge
   // that moves the item, since nothing may change between the two.
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         output logic [1:0] r);
      bit aw_t, w_t, b_t;
      int n;
      b_t = 0;
      @(posedge sys_clk_i);
      axi_q.awaddr <= a;
      axi_q.wdata <= d;
      axi_q.wstrb <= 4'hf;
      axi_q.awvalid <= 1'b1;
      axi_q.wvalid <= 1'b1;
      axi_q.bready <= 1'b1;
      for (n = 0; n < 200 && !b_t; n++) begin
         @(negedge sys_clk_i);
         aw_t = axi_q.awvalid && axi_rsp.awready;
         w_t = axi_q.wvalid && axi_rsp.wready;
         b_t = axi_rsp.bvalid;
         r = axi_rsp.bresp;
         @(posedge sys_clk_i);
         if (aw_t) axi_q.awvalid <= 1'b0;
         if (w_t) axi_q.wvalid <= 1'b0;
         if (b_t) axi_q.bready <= 1'b0;
      end
      if (!b_t) chk_val(32'h0, 32'h1);
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      bit ar_t, r_t;
      int n;
      r_t = 0;
      @(posedge sys_clk_i);
      axi_q.araddr <= a;
      axi_q.arvalid <= 1'b1;
      axi_q.rready <= 1'b1;
      for (n = 0; n < 200 && !r_t; n++) begin
         @(negedge sys_clk_i);
         ar_t = axi_q.arvalid && axi_rsp.arready;
         r_t = axi_rsp.rvalid;
         d = axi_rsp.rdata;
         r = axi_rsp.rresp;
         @(posedge sys_clk_i);
         if (ar_t) axi_q.arvalid <= 1'b0;
         if (r_t) axi_q.rready <= 1'b0;
      end
      if (!r_t) chk_val(32'h0, 32'h1);
   endtask

   // --------------------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------------------
   task automatic t_regs();
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(SADC_PORT_OFS, d, r);
      chk_val(d, 32'(SADC_CTRL_RST));
      axi_rd(SADC_SDIV_OFS, d, r);
      chk_val(d, 32'(SADC_SDIV_RST));
      axi_rd(SADC_MDIV_OFS, d, r);
      chk_val(d, 32'(SADC_MDIV_RST));
      axi_rd(8'h20, d, r);
      chk_resp(r, SADC_RESP_SLVERR);
      axi_wr(SADC_SDIV_OFS, 32'h3, r);
      chk_resp(r, SADC_RESP_OKAY);
      axi_wr(SADC_MDIV_OFS, 32'h1, r);
      axi_wr(SADC_IMSK_OFS, 32'h1, r);
   endtask

   task automatic t_frame(input logic [4:0] len, input logic [7:0] cfg,
                          input logic [15:0] pat, input logic [15:0] exp,
                          input bit w1c);
      logic [31:0] d;
      logic [1:0] r;
      int n;
      m_len <= len;
      m_pat <= pat;
      axi_wr(SADC_PORT_OFS, {16'h0, 3'b110, len, cfg}, r);
      axi_rd(SADC_STAT_OFS, d, r);
      chk_val(d, 32'h1);
      for (n = 0; n < 3000 && irq !== 1'b1; n++) @(negedge sys_clk_i);
      chk_val(32'(irq), 32'h1);
      axi_rd(SADC_STAT_OFS, d, r);
      chk_val(d, 32'h0);
      chk_val(fr_n, 32'(len));
      chk_val(32'(sync_ok), 32'h1);
      if (len >= 5'd8) chk_val(32'(shb), 32'(cfg));
      if (w1c) begin
         axi_wr(SADC_ISTS_OFS, 32'h1, r);
         chk_val(32'(irq), 32'h0);
      end
      axi_rd(SADC_PORT_OFS, d, r);
      chk_val(d, 32'(exp));
      chk_val(32'(irq), 32'h0);
   endtask

   task automatic t_noinit();
      logic [1:0] r;
      int base, f0;
      base = sk_n;
      f0 = fr_n;
      axi_wr(SADC_PORT_OFS, 32'h2000 | 32'h0400, r);
      repeat (100) @(negedge sys_clk_i);
      chk_val(fr_n, f0);
      chk_val(32'(sk_n - base > 23 && sk_n - base < 27), 32'h1);
      axi_wr(SADC_PORT_OFS, 32'h0, r);
      repeat (20) @(negedge sys_clk_i);
      base = sk_n;
      repeat (50) @(negedge sys_clk_i);
      chk_val(sk_n - base, 0);
   endtask

   task automatic t_mask();
      logic [31:0] d;
      logic [1:0] r;
      axi_wr(SADC_IMSK_OFS, 32'h0, r);
      axi_wr(SADC_PORT_OFS, 32'h4181, r);
      repeat (60) @(negedge sys_clk_i);
      chk_val(32'(irq), 32'h0);
      axi_rd(SADC_ISTS_OFS, d, r);
      chk_val(d, 32'h1);
      axi_wr(SADC_ISTS_OFS, 32'h1, r);
      axi_rd(SADC_ISTS_OFS, d, r);
      chk_val(d, 32'h0);
      axi_wr(SADC_IMSK_OFS, 32'h1, r);
   endtask

   task automatic close_out();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      repeat (12) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      t_regs();
      t_frame(5'd16, 8'ha5, 16'hc3a9, 16'hc3a9, 1'b0);
      t_frame(5'd8, 8'h3c, 16'h5e17, 16'ha95e, 1'b1);
      t_frame(5'd0, 8'h00, 16'h0000, 16'ha95e, 1'b0);
      t_noinit();
      t_mask();
      close_out();
   end

   initial begin
      #4000000;
      miscompares++;
      close_out();
   end
endmodule
`default_nettype wire

// File: inc/sadc_pkg.sv
// Package of shared constants and carrier types for the serial converter port.
package sadc_pkg;

   // ---------------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------------
   typedef logic [7:0] sadc_addr_t;
   localparam sadc_addr_t SADC_PORT_OFS = 8'h00;
   localparam sadc_addr_t SADC_STAT_OFS = 8'h04;
   localparam sadc_addr_t SADC_ISTS_OFS = 8'h08;
   localparam sadc_addr_t SADC_IMSK_OFS = 8'h0c;
   localparam sadc_addr_t SADC_SDIV_OFS = 8'h10;
   localparam sadc_addr_t SADC_MDIV_OFS = 8'h14;

   // ---------------------------------------------------------------------
   // Field layout of the port register write side, plus the busy and end-of-transfer bits
   // ---------------------------------------------------------------------
   localparam int unsigned SADC_CFG_LSB = 0;
   localparam int unsigned SADC_CFG_MSB = 7;
   localparam int unsigned SADC_LEN_LSB = 8;
   localparam int unsigned SADC_LEN_MSB = 12;
   localparam int unsigned SADC_SMCK_BIT = 13;
   localparam int unsigned SADC_INIT_BIT = 14;
   localparam int unsigned SADC_RSVD_BIT = 15;
   localparam int unsigned SADC_BUSY_BIT = 0;
   localparam int unsigned SADC_EOT_BIT = 0;

   // ---------------------------------------------------------------------
   // Reset values and fixed codes
   // ---------------------------------------------------------------------
   localparam logic [15:0] SADC_CTRL_RST = 16'h0000;
   localparam logic [15:0] SADC_SDIV_RST = 16'h0004;
   localparam logic [15:0] SADC_MDIV_RST = 16'h0031;
   localparam logic [1:0] SADC_RESP_OKAY = 2'b00;
   localparam logic [1:0] SADC_RESP_SLVERR = 2'b10;

   // ---------------------------------------------------------------------
   // Carrier types
   // ---------------------------------------------------------------------
   typedef struct packed {
      logic awvalid;
      sadc_addr_t awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      sadc_addr_t araddr;
      logic rready;
   } sadc_axi_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } sadc_axi_rsp_s;

   typedef struct packed {
      logic shift_clk;
      logic sync_pulse;
      logic serial_out;
      logic sample_clk;
   } sadc_link_s;

endpackage

// File: rtl/sadc_sync2.sv
// Two-stage synchroniser for one level from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none
module sadc_sync2 (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   // Level
   input wire logic d_i,
   output logic q_o
);
   logic meta_q;
   logic q_q;

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta_q <= 1'b0;
         q_q <= 1'b0;
      end else begin
         meta_q <= d_i;
         q_q <= meta_q;
      end
   end

   assign q_o = q_q;
endmodule
`default_nettype wire

// File: rtl/sadc_tick_gen.sv
// Programmable divider that pulses once every div_i plus one cycles.
`timescale 1ns/100ps
`default_nettype none
module sadc_tick_gen (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   // Control
   input wire logic run_i,
   input wire logic [15:0] div_i,
   // Output
   output logic tick_o
);
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   wire at_zero = (cnt_q == 16'h0000);

   // The counter restarts from the divisor whenever it is stopped.
   assign cnt_d = (!run_i || at_zero) ? div_i : cnt_q - 16'h0001;
   assign tick_o = run_i & at_zero;

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_q <= 16'h0000;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule
`default_nettype wire

// File: rtl/sadc_top.sv
// Serial converter port with its register bus slave and interrupt.
//
// Contract
// - Sixteen bit port register, write control, read data.
// - Transfer request serialises configuration byte out.
// - Shift clock starts by itself at programmed rate.
// - Synchronisation pulse at start of each transfer.
// - Sample converter input each shift clock, shift in.
// - Busy flag high throughout the data transfer.
// - Transfer completion raises end-of-transfer interrupt.
// - Reading port register clears end-of-transfer interrupt.
// - Read returns last sixteen bits shifted in.
// - Frame length field sets shift clock count.
// - Sample clock enable gives free-running sample clock.
// - Initiate bit set on write starts transfer; a write while busy starts none.
// - Low byte shifted out during started transfer.
// - Capture as many bits as frame length.
`timescale 1ns/100ps
`default_nettype none
module sadc_top (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   // Register bus
   input wire sadc_pkg::sadc_axi_req_s axi_i,
   output sadc_pkg::sadc_axi_rsp_s axi_o,
   // Converter link
   input wire logic converter_serial_in_i,
   output sadc_pkg::sadc_link_s link_o,
   // Interrupt
   output logic irq_o
);
   import sadc_pkg::*;

   typedef enum logic [1:0] {
      SADC_IDLE,
      SADC_SYNC,
      SADC_HIGH,
      SADC_LOW
   } sadc_state_e;

   // ---------------------------------------------------------------------
   // Register bus slave
   // ---------------------------------------------------------------------
   logic aw_have_q;
   logic w_have_q;
   sadc_addr_t aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic [31:0] rdata_d;
   logic rd_hit;

   wire awready = !aw_have_q && !bvalid_q;
   wire wready = !w_have_q && !bvalid_q;
   wire aw_take = axi_i.awvalid && awready;
   wire w_take = axi_i.wvalid && wready;
   wire wr_fire = aw_have_q && w_have_q && !bvalid_q;
   wire arready = !rvalid_q;
   wire rd_take = axi_i.arvalid && arready;

   wire wr_port = wr_fire && (aw_addr_q == SADC_PORT_OFS);
   wire wr_ists = wr_fire && (aw_addr_q == SADC_ISTS_OFS);
   wire wr_imsk = wr_fire && (aw_addr_q == SADC_IMSK_OFS);
   wire wr_sdiv = wr_fire && (aw_addr_q == SADC_SDIV_OFS);
   wire wr_mdiv = wr_fire && (aw_addr_q == SADC_MDIV_OFS);
   wire wr_stat = wr_fire && (aw_addr_q == SADC_STAT_OFS);
   wire wr_hit = wr_port | wr_ists | wr_imsk | wr_sdiv | wr_mdiv | wr_stat;
   wire rd_port = rd_take && (axi_i.araddr == SADC_PORT_OFS);

   // Byte lanes that are not strobed keep their old contents.
   function automatic logic [31:0] sadc_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= '0;
      end else if (aw_take) begin
         aw_have_q <= 1'b1;
         aw_addr_q <= axi_i.awaddr;
      end else if (wr_fire) begin
         aw_have_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         w_have_q <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end else if (w_take) begin
         w_have_q <= 1'b1;
         w_data_q <= axi_i.wdata;
         w_strb_q <= axi_i.wstrb;
      end else if (wr_fire) begin
         w_have_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         bvalid_q <= 1'b0;
         bresp_q <= SADC_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_hit ? SADC_RESP_OKAY : SADC_RESP_SLVERR;
      end else if (axi_i.bready) begin
         bvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= SADC_RESP_OKAY;
      end else if (rd_take) begin
         rvalid_q <= 1'b1;
         rdata_q <= rdata_d;
         rresp_q <= rd_hit ? SADC_RESP_OKAY : SADC_RESP_SLVERR;
      end else if (axi_i.rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------------
   // Control and interrupt registers
   // ---------------------------------------------------------------------
   logic [15:0] ctrl_q;
   logic [15:0] sdiv_q;
   logic [15:0] mdiv_q;
   logic eot_sts_q;
   logic eot_msk_q;
   logic [15:0] shift_q;
   sadc_state_e state_q;
   logic xfer_done;

   wire [31:0] port_new = sadc_merge({16'h0000, ctrl_q}, w_data_q, w_strb_q);
   wire [31:0] sdiv_new = sadc_merge({16'h0000, sdiv_q}, w_data_q, w_strb_q);
   wire [31:0] mdiv_new = sadc_merge({16'h0000, mdiv_q}, w_data_q, w_strb_q);
   wire init_req = port_new[SADC_INIT_BIT];
   wire busy = (state_q != SADC_IDLE);
   wire [4:0] frame_len = ctrl_q[SADC_LEN_MSB:SADC_LEN_LSB];
   wire smck_en = ctrl_q[SADC_SMCK_BIT];
   wire [7:0] cfg_byte = ctrl_q[SADC_CFG_MSB:SADC_CFG_LSB];
   wire start = wr_port && init_req && !busy;
   wire eot_clr = rd_port || (wr_ists && w_strb_q[0] &&
                              w_data_q[SADC_EOT_BIT]);

   // The initiate and reserved bits are never stored.
   wire [15:0] ctrl_d = {2'b00, port_new[SADC_SMCK_BIT:SADC_CFG_LSB]};

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl_q <= SADC_CTRL_RST;
      end else if (wr_port) begin
         ctrl_q <= ctrl_d;
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sdiv_q <= SADC_SDIV_RST;
         mdiv_q <= SADC_MDIV_RST;
         eot_msk_q <= 1'b0;
      end else begin
         if (wr_sdiv) sdiv_q <= sdiv_new[15:0];
         if (wr_mdiv) mdiv_q <= mdiv_new[15:0];
         if (wr_imsk && w_strb_q[0]) eot_msk_q <= w_data_q[SADC_EOT_BIT];
      end
   end

   // A completion in the cycle of a clear keeps the flag set.
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         eot_sts_q <= 1'b0;
      end else if (xfer_done) begin
         eot_sts_q <= 1'b1;
      end else if (eot_clr) begin
         eot_sts_q <= 1'b0;
      end
   end

   assign irq_o = eot_sts_q & eot_msk_q;

   assign rd_hit = (axi_i.araddr == SADC_PORT_OFS) ||
                   (axi_i.araddr == SADC_STAT_OFS) ||
                   (axi_i.araddr == SADC_ISTS_OFS) ||
                   (axi_i.araddr == SADC_IMSK_OFS) ||
                   (axi_i.araddr == SADC_SDIV_OFS) ||
                   (axi_i.araddr == SADC_MDIV_OFS);

   always_comb begin
      rdata_d = 32'h0000_0000;
      case (axi_i.araddr)
         SADC_PORT_OFS: rdata_d[15:0] = shift_q;
         SADC_STAT_OFS: rdata_d[SADC_BUSY_BIT] = busy;
         SADC_ISTS_OFS: rdata_d[SADC_EOT_BIT] = eot_sts_q;
         SADC_IMSK_OFS: rdata_d[SADC_EOT_BIT] = eot_msk_q;
         SADC_SDIV_OFS: rdata_d[15:0] = sdiv_q;
         SADC_MDIV_OFS: rdata_d[15:0] = mdiv_q;
         default: rdata_d = 32'h0000_0000;
      endcase
   end

   assign axi_o.awready = awready;
   assign axi_o.wready = wready;
   assign axi_o.bvalid = bvalid_q;
   assign axi_o.bresp = bresp_q;
   assign axi_o.arready = arready;
   assign axi_o.rvalid = rvalid_q;
   assign axi_o.rdata = rdata_q;
   assign axi_o.rresp = rresp_q;

   // ---------------------------------------------------------------------
   // Shift engine
   // ---------------------------------------------------------------------
   logic adc_in_s;
   logic shift_tick;
   sadc_state_e state_d;
   logic [4:0] bit_cnt_q;
   logic [4:0] bit_cnt_d;
   logic [7:0] tx_q;
   logic [7:0] tx_d;
   logic [15:0] shift_d;
   logic sclk_q;
   logic sclk_d;
   logic sync_q;
   logic sync_d;
   logic sdo_q;
   logic sdo_d;

   sadc_sync2 u_adc_sync (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .d_i(converter_serial_in_i),
      .q_o(adc_in_s)
   );

   sadc_tick_gen u_shift_div (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .run_i(busy),
      .div_i(sdiv_q),
      .tick_o(shift_tick)
   );

   wire last_clk = (bit_cnt_q == frame_len);
   wire [15:0] shift_in = {shift_q[14:0], adc_in_s};

   assign xfer_done = shift_tick &&
                      (((state_q == SADC_SYNC) && (frame_len == 5'h00)) ||
                       ((state_q == SADC_HIGH) && last_clk));

   always_comb begin
      state_d = state_q;
      bit_cnt_d = bit_cnt_q;
      tx_d = tx_q;
      shift_d = shift_q;
      sclk_d = sclk_q;
      sync_d = sync_q;
      sdo_d = sdo_q;
      case (state_q)
         SADC_IDLE: begin
            if (start) begin
               state_d = SADC_SYNC;
               sync_d = 1'b1;
               sdo_d = port_new[SADC_CFG_MSB];
               tx_d = {port_new[SADC_CFG_MSB-1:SADC_CFG_LSB], 1'b0};
               bit_cnt_d = 5'h00;
               sclk_d = 1'b0;
            end
         end
         SADC_SYNC: begin
            if (shift_tick) begin
               sync_d = 1'b0;
               if (frame_len == 5'h00) begin
                  state_d = SADC_IDLE;
               end else begin
                  state_d = SADC_HIGH;
                  sclk_d = 1'b1;
                  bit_cnt_d = bit_cnt_q + 5'h01;
                  shift_d = shift_in;
               end
            end
         end
         SADC_HIGH: begin
            if (shift_tick) begin
               sclk_d = 1'b0;
               if (last_clk) begin
                  state_d = SADC_IDLE;
                  sdo_d = 1'b0;
               end else begin
                  state_d = SADC_LOW;
                  sdo_d = tx_q[7];
                  tx_d = {tx_q[6:0], 1'b0};
               end
            end
         end
         SADC_LOW: begin
            if (shift_tick) begin
               state_d = SADC_HIGH;
               sclk_d = 1'b1;
               bit_cnt_d = bit_cnt_q + 5'h01;
               shift_d = shift_in;
            end
         end
         default: begin
            state_d = SADC_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_q <= SADC_IDLE;
         bit_cnt_q <= 5'h00;
         tx_q <= 8'h00;
         shift_q <= 16'h0000;
      end else begin
         state_q <= state_d;
         bit_cnt_q <= bit_cnt_d;
         tx_q <= tx_d;
         shift_q <= shift_d;
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sclk_q <= 1'b0;
         sync_q <= 1'b0;
         sdo_q <= 1'b0;
      end else begin
         sclk_q <= sclk_d;
         sync_q <= sync_d;
         sdo_q <= sdo_d;
      end
   end

   // ---------------------------------------------------------------------
   // Free-running sample clock
   // ---------------------------------------------------------------------
   logic smp_tick;
   logic smp_q;

   sadc_tick_gen u_smp_div (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .run_i(smck_en),
      .div_i(mdiv_q),
      .tick_o(smp_tick)
   );

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         smp_q <= 1'b0;
      end else if (!smck_en) begin
         smp_q <= 1'b0;
      end else if (smp_tick) begin
         smp_q <= !smp_q;
      end
   end

   assign link_o.shift_clk = sclk_q;
   assign link_o.sync_pulse = sync_q;
   assign link_o.serial_out = sdo_q;
   assign link_o.sample_clk = smp_q;

   // ---------------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------------
   logic [5:0] rise_cnt_q;

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rise_cnt_q <= 6'h00;
      end else if (start) begin
         rise_cnt_q <= 6'h00;
      end else if (sclk_d && !sclk_q) begin
         rise_cnt_q <= rise_cnt_q + 6'h01;
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);

   sequence sadc_start_s;
      wr_port && init_req && !busy;
   endsequence

   sequence sadc_sync_phase_s;
      sync_q && !sclk_q && busy;
   endsequence

   busy_whole_xfer_a: assert property (
      (busy && !xfer_done) |=> busy)
      else $error("busy flag low during transfer");

   init_starts_a: assert property (
      sadc_start_s |=> sadc_sync_phase_s)
      else $error("initiate write did not start transfer");

   no_init_idle_a: assert property (
      (wr_port && !init_req && !busy) |=>
      !busy && (ctrl_q == $past(ctrl_d)))
      else $error("write without initiate misbehaved");

   sync_first_bit_a: assert property (
      sadc_start_s |=> sync_q && (sdo_q == $past(port_new[SADC_CFG_MSB])))
      else $error("sync pulse or first bit wrong");

   clk_count_a: assert property (
      $fell(busy) |-> (rise_cnt_q == {1'b0, frame_len}) && !sclk_q)
      else $error("shift clock count differs from frame length");

   eot_on_end_a: assert property (
      $fell(busy) |-> eot_sts_q)
      else $error("end of transfer flag not set");

   read_clears_a: assert property (
      (rd_port && !xfer_done) |=> !eot_sts_q)
      else $error("port read did not clear end of transfer");

   sample_shift_a: assert property (
      (sclk_d && !sclk_q) |=> shift_q == {$past(shift_q[14:0]),
                                           $past(adc_in_s)})
      else $error("input bit not shifted in at clock rise");

   read_data_a: assert property (
      rd_port |=> rvalid_q && (rdata_q[15:0] == $past(shift_q)))
      else $error("port read returned wrong data");

   smp_off_a: assert property (
      !smck_en |=> !smp_q)
      else $error("sample clock runs while disabled");

   idle_quiet_a: assert property (
      !busy |-> !sclk_q && !sync_q)
      else $error("shift clock or sync active while idle");

   cfg_bits_a: assert property (
      (state_q == SADC_HIGH) && shift_tick && !last_clk &&
      (bit_cnt_q < 5'h08) |=> sdo_q == $past(tx_q[7]))
      else $error("configuration bit out of order");

   rsvd_clear_a: assert property (
      (wr_port && (w_strb_q[1:0] == 2'b11)) |=>
      (ctrl_q == {2'b00, $past(w_data_q[SADC_SMCK_BIT:SADC_CFG_LSB])}))
      else $error("reserved or initiate bit stored");

endmodule
`default_nettype wire
